// *** isahd_top.sv ***
// Host bus configuration, decode and routing for the controller core
//
// Function
// - Mode switch selects contiguous or sparse decode
// - Contiguous base multiple of 8, 100..3F8
// - Contiguous compares address bits A3..A9
// - Contiguous block of eight addresses
// - Sparse base from two switches, four choices
// - Sparse decodes 16 spread addresses
// - Switch at 1 side is logic one
// - Personality switch, primary is default
// - IRQ onto line 2..7 or none
// - DMA on channel 1..3 or none
// - Sparse IRQ shared, contiguous exclusive
// - Defaults 2B8 contiguous, 2E1 sparse
// - DMA pair follows selected channel
// - Sparse reads three IRQ level switches
`timescale 1ns/1ns
`default_nettype none
module isahd_top
  import isahd_pkg::*;
#(
  parameter int HIT_W = 16
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             int_o,
  // Configuration switch block and jumpers (pins)
  input  wire logic                        sw_sparse_mode_i,
  input  wire logic                        sw_pers_alt_i,
  input  wire logic [6:0]                  sw_base_i,
  input  wire logic [1:0]                  sw_sparse_sel_i,
  input  wire logic [2:0]                  irq_level_switch_i,
  input  wire logic [2:0]                  irq_jumper_i,
  input  wire logic [1:0]                  dma_jumper_i,
  // Host expansion bus (pins)
  input  wire logic [isahd_pkg::ISA_AW-1:0] isa_addr_i,
  input  wire logic                        isa_aen_i,
  input  wire logic                        isa_ior_n_i,
  input  wire logic                        isa_iow_n_i,
  input  wire logic [isahd_pkg::ISA_DW-1:0] isa_data_i,
  output logic      [isahd_pkg::ISA_DW-1:0] isa_data_o,
  output logic                             isa_data_oe_n_o,
  output logic      [isahd_pkg::IRQ_N-1:0] isa_irq_o,
  output logic      [isahd_pkg::IRQ_N-1:0] isa_irq_oe_n_o,
  output logic      [isahd_pkg::DMA_N-1:0] isa_drq_o,
  output logic      [isahd_pkg::DMA_N-1:0] isa_drq_oe_n_o,
  input  wire logic [isahd_pkg::DMA_N-1:0] isa_dack_n_i,
  // Controller core side
  output var isahd_pkg::isahd_core_t       core_o,
  input  wire logic [isahd_pkg::ISA_DW-1:0] core_rdata_i,
  input  wire logic                        core_irq_i,
  input  wire logic                        core_drq_i,
  output logic                             core_dack_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW_W  = 1 + 1 + 7 + 2 + 3 + 3 + 2;
  localparam int BUS_W = ISA_AW + 1 + ISA_DW;

  logic [SW_W-1:0]   sw_s;
  logic [BUS_W-1:0]  bus_s;
  logic [1:0]        strb_n_s;
  logic [DMA_N-1:0]  dack_n_s;

  isahd_sync #(.W(SW_W), .RST(1'b0)) u_sync_sw (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sw_sparse_mode_i, sw_pers_alt_i, sw_base_i, sw_sparse_sel_i,
             irq_level_switch_i, irq_jumper_i, dma_jumper_i}),
    .q_o   (sw_s)
  );

  isahd_sync #(.W(BUS_W), .RST(1'b0)) u_sync_bus (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({isa_addr_i, isa_aen_i, isa_data_i}),
    .q_o   (bus_s)
  );

  isahd_sync #(.W(2), .RST(1'b1)) u_sync_strb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({isa_ior_n_i, isa_iow_n_i}),
    .q_o   (strb_n_s)
  );

  isahd_sync #(.W(DMA_N), .RST(1'b1)) u_sync_dack (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (isa_dack_n_i),
    .q_o   (dack_n_s)
  );

  logic [ISA_AW-1:0] addr_s;
  logic              aen_s;
  logic [ISA_DW-1:0] data_s;
  logic              ior_s;
  logic              iow_s;
  logic [2:0]        lvl_sw_s;
  logic [2:0]        jmp_irq_s;

  assign addr_s    = bus_s[BUS_W-1 -: ISA_AW];
  assign aen_s     = bus_s[ISA_DW];
  assign data_s    = bus_s[ISA_DW-1:0];
  assign ior_s     = ~strb_n_s[1];
  assign iow_s     = ~strb_n_s[0];
  assign lvl_sw_s  = sw_s[7:5];
  assign jmp_irq_s = sw_s[4:2];

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  isahd_cfg_t cfg_r;
  isahd_cfg_t cfg_nxt;
  logic       cfg_chg;

  always_comb begin
    cfg_nxt          = CFG_RST;
    cfg_nxt.sparse   = sw_s[SW_W-1];
    cfg_nxt.pers_alt = sw_s[SW_W-2];
    cfg_nxt.base     = sw_s[SW_W-3 -: 7];
    cfg_nxt.sp_sel   = sw_s[9:8];
    cfg_nxt.irq_line = sw_s[SW_W-1] ? lvl_sw_s : jmp_irq_s;
    cfg_nxt.dma_ch   = sw_s[1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg_chg = (cfg_nxt != cfg_r);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic             hit;
  logic [IDX_W-1:0] idx;
  logic             sel;

  isahd_decode u_decode (
    .cfg_i  (cfg_r),
    .addr_i (addr_s),
    .hit_o  (hit),
    .idx_o  (idx)
  );

  // DMA cycles (AEN high) never select the board
  assign sel = hit && !aen_s;

  // ----------------------------------------------------------------
  // Host I/O cycles toward the core
  // ----------------------------------------------------------------
  logic ior_d_r;
  logic iow_d_r;
  logic rd_start;
  logic wr_start;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ior_d_r <= 1'b0;
      iow_d_r <= 1'b0;
    end else begin
      ior_d_r <= ior_s;
      iow_d_r <= iow_s;
    end
  end

  // strobes only on a decoded hit
  assign rd_start = ior_s && !ior_d_r && sel;
  assign wr_start = iow_s && !iow_d_r && sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_o <= '0;
    end else begin
      core_o.rd       <= rd_start;
      core_o.wr       <= wr_start;
      core_o.pers_alt <= cfg_r.pers_alt;
      // index and data held on a miss
      if (rd_start || wr_start) begin
        core_o.idx   <= idx;
        core_o.wdata <= data_s;
      end
    end
  end

  // data bus driven only on a read hit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isa_data_oe_n_o <= 1'b1;
      isa_data_o      <= '0;
    end else begin
      isa_data_oe_n_o <= !(ior_s && sel);
      if (ior_s && sel) begin
        isa_data_o <= core_rdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line routing
  // ----------------------------------------------------------------
  logic [1:0]       ctrl_r;
  logic [IRQ_N-1:0] irq_sel;

  assign irq_sel = ctrl_r[CTRL_IRQ_EN] ? irq_onehot(cfg_r.irq_line) : '0;

  // drive one of lines 2..7 or none
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isa_irq_o      <= '0;
      isa_irq_oe_n_o <= '1;
    end else if (cfg_r.sparse) begin
      isa_irq_o      <= irq_sel;
      isa_irq_oe_n_o <= ~(irq_sel & {IRQ_N{core_irq_i}});
    end else begin
      isa_irq_o      <= irq_sel & {IRQ_N{core_irq_i}};
      isa_irq_oe_n_o <= ~irq_sel;
    end
  end

  // ----------------------------------------------------------------
  // DMA channel routing
  // ----------------------------------------------------------------
  logic [DMA_N-1:0] dma_sel;

  assign dma_sel = ctrl_r[CTRL_DMA_EN] ? dma_onehot(cfg_r.dma_ch) : '0;

  // request and acknowledge of one channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isa_drq_o      <= '0;
      isa_drq_oe_n_o <= '1;
      core_dack_o    <= 1'b0;
    end else begin
      isa_drq_o      <= dma_sel & {DMA_N{core_drq_i}};
      isa_drq_oe_n_o <= ~dma_sel;
      core_dack_o    <= |(dma_sel & ~dack_n_s);
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register file
  // ----------------------------------------------------------------
  logic             wb_req;
  logic             wb_wr;
  logic [EVT_N-1:0] evt_r;
  logic [EVT_N-1:0] mask_r;
  logic [EVT_N-1:0] evt_set;
  logic [HIT_W-1:0] hits_r;
  logic             core_irq_d_r;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wb_wr && wb_adr_i == REG_CTRL) begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RST;
    end else if (wb_wr && wb_adr_i == REG_MASK) begin
      mask_r <= wb_dat_i[EVT_N-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_irq_d_r <= 1'b0;
    end else begin
      core_irq_d_r <= core_irq_i;
    end
  end

  always_comb begin
    evt_set         = '0;
    evt_set[EV_RD]  = rd_start;
    evt_set[EV_WR]  = wr_start;
    evt_set[EV_IRQ] = core_irq_i && !core_irq_d_r;
    evt_set[EV_CFG] = cfg_chg;
  end

  // Set beats write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_r <= '0;
    end else if (wb_wr && wb_adr_i == REG_EVT) begin
      evt_r <= (evt_r & ~wb_dat_i[EVT_N-1:0]) | evt_set;
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hits_r <= '0;
    end else if (rd_start || wr_start) begin
      hits_r <= hits_r + HIT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= |(evt_r & mask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: wb_dat_o <= {30'h0, ctrl_r};
        REG_CFG:  wb_dat_o <= {16'h0, cfg_r};
        REG_EVT:  wb_dat_o <= {28'h0, evt_r};
        REG_MASK: wb_dat_o <= {28'h0, mask_r};
        REG_HITS: wb_dat_o <= 32'(hits_r);
        default:  wb_dat_o <= '0;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** isahd_pkg.sv ***
// Shared constants, types and helpers for the host decode block
package isahd_pkg;

  // ----------------------------------------------------------------
  // Host bus geometry
  // ----------------------------------------------------------------
  localparam int ISA_AW = 16;
  localparam int ISA_DW = 8;
  localparam int IDX_W  = 4;

  // Contiguous mode: base compared on A3..A9, range 100..3F8
  localparam int                CONT_LO_BIT  = 3;
  localparam int                CONT_HI_BIT  = 9;
  localparam logic [ISA_AW-1:0] CONT_MIN     = 16'h0100;
  localparam logic [ISA_AW-1:0] CONT_MAX     = 16'h03F8;

  // Sparse mode: four bases, 16 addresses spread by A10..A12 and A15
  localparam logic [ISA_AW-1:0] SPARSE_BASE0 = 16'h02E1;
  localparam logic [ISA_AW-1:0] SPARSE_BASE1 = 16'h22E1;
  localparam logic [ISA_AW-1:0] SPARSE_BASE2 = 16'h42E1;
  localparam logic [ISA_AW-1:0] SPARSE_BASE3 = 16'h62E1;
  localparam logic [9:0]        SPARSE_LOW   = 10'h2E1;

  // ----------------------------------------------------------------
  // Factory defaults
  // ----------------------------------------------------------------
  localparam logic [ISA_AW-1:0] DEF_CONT_BASE = 16'h02B8;
  localparam logic [1:0]        DEF_SP_SEL    = 2'h0;
  localparam logic [2:0]        DEF_IRQ_LINE  = 3'h7;
  localparam logic [1:0]        DEF_DMA_CH    = 2'h1;
  localparam logic              DEF_PERS_ALT  = 1'b0;

  // IRQ lines 2..7 and DMA channels 1..3 exist on the host bus
  localparam int IRQ_FIRST = 2;
  localparam int IRQ_N     = 6;
  localparam int DMA_N     = 3;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_CFG   = 8'h04;
  localparam logic [7:0]  REG_EVT   = 8'h08;
  localparam logic [7:0]  REG_MASK  = 8'h0C;
  localparam logic [7:0]  REG_HITS  = 8'h10;
  localparam logic [1:0]  CTRL_RST  = 2'h3;
  localparam logic [3:0]  MASK_RST  = 4'h0;
  localparam int          EVT_N     = 4;
  localparam int EV_RD   = 0;
  localparam int EV_WR   = 1;
  localparam int EV_IRQ  = 2;
  localparam int EV_CFG  = 3;
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_DMA_EN = 1;

  // Switch-set configuration as seen by the logic
  typedef struct packed {
    logic       sparse;
    logic       pers_alt;
    logic [6:0] base;
    logic [1:0] sp_sel;
    logic [2:0] irq_line;
    logic [1:0] dma_ch;
  } isahd_cfg_t;

  localparam isahd_cfg_t CFG_RST = '{
    sparse:   1'b0,
    pers_alt: DEF_PERS_ALT,
    base:     DEF_CONT_BASE[CONT_HI_BIT:CONT_LO_BIT],
    sp_sel:   DEF_SP_SEL,
    irq_line: DEF_IRQ_LINE,
    dma_ch:   DEF_DMA_CH
  };

  // Access toward the controller core
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              pers_alt;
    logic [IDX_W-1:0]  idx;
    logic [ISA_DW-1:0] wdata;
  } isahd_core_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot of IRQ line 2..7; 0 and 1 mean no line
  function automatic logic [IRQ_N-1:0] irq_onehot(input logic [2:0] line);
    logic [IRQ_N-1:0] v;
    v = '0;
    if (line >= 3'(IRQ_FIRST)) begin
      v[3'(line - 3'(IRQ_FIRST))] = 1'b1;
    end
    return v;
  endfunction

  // One-hot of DMA channel 1..3; 0 means none
  function automatic logic [DMA_N-1:0] dma_onehot(input logic [1:0] ch);
    logic [DMA_N-1:0] v;
    v = '0;
    if (ch != 2'h0) begin
      v[2'(ch - 2'h1)] = 1'b1;
    end
    return v;
  endfunction

endpackage

// *** isahd_sync.sv ***
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ns
`default_nettype none
module isahd_sync #(
  parameter int        W   = 1,
  parameter logic      RST = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{RST}};
      q_o    <= {W{RST}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** isahd_decode.sv ***
// Host address decode for both decode modes
`timescale 1ns/1ns
`default_nettype none
module isahd_decode
  import isahd_pkg::*;
(
  input  wire isahd_pkg::isahd_cfg_t         cfg_i,
  input  wire logic [isahd_pkg::ISA_AW-1:0]  addr_i,
  output logic                               hit_o,
  output logic      [isahd_pkg::IDX_W-1:0]   idx_o
);
  logic [ISA_AW-1:0] cont_base;
  logic              cont_ok;
  logic              cont_hit;
  logic              sp_hit;

  // switch at 1 side reads as one
  assign cont_base = {6'h00, cfg_i.base, 3'h0};
  assign cont_ok   = (cont_base >= CONT_MIN) && (cont_base <= CONT_MAX);
  assign cont_hit  = cont_ok && (addr_i[ISA_AW-1:CONT_HI_BIT+1] == '0)
                  && (addr_i[CONT_HI_BIT:CONT_LO_BIT] == cfg_i.base);
  // 16 addresses spread over upper space
  assign sp_hit    = (addr_i[9:0] == SPARSE_LOW)
                  && (addr_i[14:13] == cfg_i.sp_sel);

  // mode switch picks the decode region
  always_comb begin
    if (cfg_i.sparse) begin
      hit_o = sp_hit;
      idx_o = {addr_i[15], addr_i[12:10]};
    end else begin
      hit_o = cont_hit;
      idx_o = {1'b0, addr_i[2:0]};
    end
  end
endmodule
`default_nettype wire

// *** isahd_checker.sv ***
// Port-level assertions for the host decode top
`timescale 1ns/1ns
`default_nettype none
module isahd_checker
  import isahd_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_ack_o,
  input wire logic                         sw_sparse_mode_i,
  input wire logic [2:0]                   irq_level_switch_i,
  input wire logic [2:0]                   irq_jumper_i,
  input wire logic [1:0]                   dma_jumper_i,
  input wire logic                         isa_aen_i,
  input wire logic                         isa_ior_n_i,
  input wire logic                         isa_iow_n_i,
  input wire logic                         isa_data_oe_n_o,
  input wire logic [isahd_pkg::IRQ_N-1:0]  isa_irq_o,
  input wire logic [isahd_pkg::IRQ_N-1:0]  isa_irq_oe_n_o,
  input wire logic [isahd_pkg::DMA_N-1:0]  isa_drq_oe_n_o,
  input wire isahd_pkg::isahd_core_t       core_o
);
  // --------------------------------------
  // Properties
  // --------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  AST_DATA_QUIET: assert property (isa_ior_n_i [*5] |=> isa_data_oe_n_o)
    else $error("data driven without read strobe");
  AST_WR_CAUSE: assert property (core_o.wr |->
    !$past(isa_iow_n_i, 2) && !$past(isa_aen_i, 2))
    else $error("core write without host write");
  AST_RD_CAUSE: assert property (core_o.rd |->
    !$past(isa_ior_n_i, 2) && !$past(isa_aen_i, 2))
    else $error("core read without host read");
  AST_IRQ_CONT: assert property ((!sw_sparse_mode_i
    && $stable(irq_jumper_i)) [*8] |-> (~isa_irq_oe_n_o
    & ~(6'h01 << (irq_jumper_i - 3'h2))) == 6'h00)
    else $error("wrong irq line in contiguous mode");
  AST_IRQ_SPARSE: assert property ((sw_sparse_mode_i
    && $stable(irq_level_switch_i)) [*8] |-> (~isa_irq_oe_n_o
    & ~(6'h01 << (irq_level_switch_i - 3'h2))) == 6'h00)
    else $error("wrong irq line in sparse mode");
  AST_IRQ_SHARED: assert property (sw_sparse_mode_i [*8]
    |-> (isa_irq_o | isa_irq_oe_n_o) == 6'h3F)
    else $error("shared irq line driven low");
  AST_DRQ_CH: assert property ($stable(dma_jumper_i) [*8]
    |-> (~isa_drq_oe_n_o & ~(3'h1 << (dma_jumper_i - 2'h1))) == 3'h0)
    else $error("wrong dma channel driven");

  COV_WR: cover property (core_o.wr);
  COV_RD: cover property (core_o.rd ##[1:4] !isa_data_oe_n_o);
  COV_SHARE: cover property (sw_sparse_mode_i && isa_irq_oe_n_o != 6'h3F);
endmodule

bind isahd_top isahd_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sw_sparse_mode_i(sw_sparse_mode_i),
  .irq_level_switch_i(irq_level_switch_i),
  .irq_jumper_i(irq_jumper_i), .dma_jumper_i(dma_jumper_i),
  .isa_aen_i(isa_aen_i), .isa_ior_n_i(isa_ior_n_i),
  .isa_iow_n_i(isa_iow_n_i), .isa_data_oe_n_o(isa_data_oe_n_o),
  .isa_irq_o(isa_irq_o), .isa_irq_oe_n_o(isa_irq_oe_n_o),
  .isa_drq_oe_n_o(isa_drq_oe_n_o), .core_o(core_o));
`default_nettype wire

// *** isahd_host.sv ***
// Host processor model issuing expansion bus I/O cycles
`timescale 1ns/1ns
`default_nettype none
module isahd_host
  import isahd_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic [isahd_pkg::ISA_DW-1:0] dev_data_i,
  input  wire logic                         dev_oe_n_i,
  output logic      [isahd_pkg::ISA_AW-1:0] addr_o,
  output logic                              aen_o,
  output logic                              ior_n_o,
  output logic                              iow_n_o,
  output logic      [isahd_pkg::ISA_DW-1:0] bus_o
);
  logic [ISA_DW-1:0] hdat_r;
  logic [ISA_DW-1:0] last_r;
  logic              drv_r;

  // Undriven bus toggles so stale data never looks valid
  assign bus_o = (dev_oe_n_i === 1'b0) ? dev_data_i
               : (drv_r ? hdat_r : ~last_r);

  always @(posedge clk_i) begin
    last_r <= bus_o;
  end

  initial begin
    addr_o = '0;
    aen_o = 1'b0;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    hdat_r = 8'h00;
    last_r = 8'h00;
    drv_r = 1'b0;
  end

  // --------------------------------------
  // One byte cycle, address set up early
  // --------------------------------------
  task automatic io(input logic we, input logic [15:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    hdat_r <= d;
    drv_r <= we;
    repeat (3) @(posedge clk_i);
    if (we) begin
      iow_n_o <= 1'b0;
    end else begin
      ior_n_o <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    q = bus_o;
    iow_n_o <= 1'b1;
    ior_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    drv_r <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** isa_host_decode_config_tb.sv ***
// Self-checking bench for the host decode block
`timescale 1ns/1ns
`default_nettype none
module isa_host_decode_config_tb;
  import isahd_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, int_o;
  logic        sw_sparse_mode_i, sw_pers_alt_i, isa_aen_i, isa_ior_n_i;
  logic        isa_iow_n_i, isa_data_oe_n_o, core_irq_i, core_drq_i;
  logic        core_dack_o;
  logic [7:0]  wb_adr_i, isa_data_i, isa_data_o, core_rdata_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [6:0]  sw_base_i;
  logic [1:0]  sw_sparse_sel_i, dma_jumper_i;
  logic [2:0]  irq_level_switch_i, irq_jumper_i, isa_dack_n_i;
  logic [2:0]  isa_drq_o, isa_drq_oe_n_o;
  logic [5:0]  isa_irq_o, isa_irq_oe_n_o;
  logic [15:0] isa_addr_i;
  isahd_core_t core_o;
  int          num_errors, checks_done, n_wr, n_rd;
  // {hit, base switches, host address}
  localparam logic [23:0] CT [8] = '{24'hD702B8, 24'hD702BF, 24'h5702C0,
    24'h5702B7, 24'hA00100, 24'hFF03FF, 24'h1F00F8, 24'h5782B8};

  isahd_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_o, .sw_sparse_mode_i,
    .sw_pers_alt_i, .sw_base_i, .sw_sparse_sel_i, .irq_jumper_i,
    .irq_level_switch_i, .dma_jumper_i, .isa_addr_i, .isa_aen_i, .isa_ior_n_i,
    .isa_iow_n_i, .isa_data_i, .isa_data_o, .isa_data_oe_n_o, .isa_irq_o,
    .isa_irq_oe_n_o, .isa_drq_o, .isa_drq_oe_n_o, .isa_dack_n_i, .core_o,
    .core_rdata_i, .core_irq_i, .core_drq_i, .core_dack_o);

  isahd_host host_u (.clk_i(clk_i), .dev_data_i(isa_data_o),
    .dev_oe_n_i(isa_data_oe_n_o), .addr_o(isa_addr_i), .aen_o(isa_aen_i),
    .ior_n_o(isa_ior_n_i), .iow_n_o(isa_iow_n_i), .bus_o(isa_data_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    n_wr += int'(core_o.wr === 1'b1);
    n_rd += int'(core_o.rd === 1'b1);
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // --------------------------------------
  // Bus and switch helpers
  // --------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
  endtask

  task automatic cfg(input logic sp, pa, input logic [6:0] b,
    input logic [1:0] s, input logic [2:0] lv, jp, input logic [1:0] dm);
    sw_sparse_mode_i <= sp;
    sw_pers_alt_i <= pa;
    sw_base_i <= b;
    sw_sparse_sel_i <= s;
    irq_level_switch_i <= lv;
    irq_jumper_i <= jp;
    dma_jumper_i <= dm;
    repeat (8) @(posedge clk_i);
  endtask

  // --------------------------------------
  // Scenarios
  // --------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, REG_CFG, 32'h0, q);
    chk("cfg", q, 32'h0000_2B9D);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl", q, 32'h3);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("int", {31'h0, int_o}, 32'h0);
  endtask

  task automatic t_cont;
    logic [31:0] h0, h1;
    logic [7:0]  q, w;
    int          n;
    wb(1'b0, REG_HITS, 32'h0, h0);
    w = core_o.wdata;
    for (int i = 0; i < 8; i++) begin
      cfg(1'b0, i[0], CT[i][22:16], 2'h0, 3'h7, 3'h7, 2'h1);
      n = n_wr;
      host_u.io(1'b1, CT[i][15:0], 8'(i + 'h40), q);
      chk("wr", 32'(n_wr - n), {31'h0, CT[i][23]});
      if (CT[i][23]) begin
        w = 8'(i + 'h40);
        chk("idx", {28'h0, core_o.idx}, {29'h0, CT[i][2:0]});
        chk("pers", {31'h0, core_o.pers_alt}, {31'h0, i[0]});
      end
      chk("wdata", {24'h0, core_o.wdata}, {24'h0, w});
    end
    wb(1'b0, REG_HITS, 32'h0, h1);
    chk("hits", h1 - h0, 32'h4);
  endtask

  task automatic t_sparse;
    logic [15:0] a;
    logic [7:0]  q;
    logic [3:0]  x;
    int          n;
    for (int s = 0; s < 4; s++) begin
      cfg(1'b1, 1'b0, 7'h57, 2'(s), 3'h5, 3'h7, 2'h1);
      x = 4'(s * 5);
      a = {x[3], 2'(s), x[2:0], 10'h2E1};
      core_rdata_i <= 8'(s + 'hA0);
      n = n_rd;
      host_u.io(1'b0, a, 8'h00, q);
      chk("rdata", {24'h0, q}, 32'(s + 'hA0));
      chk("rd", 32'(n_rd - n), 32'h1);
      chk("idx", {28'h0, core_o.idx}, {28'h0, x});
      n = n_rd;
      host_u.io(1'b0, a ^ 16'h2000, 8'h00, q);
      chk("miss", 32'(n_rd - n), 32'h0);
    end
  endtask

  task automatic t_irq;
    logic [31:0] q;
    logic [7:0]  d;
    wb(1'b1, REG_MASK, 32'h0, q);
    wb(1'b1, REG_EVT, 32'hF, q);
    host_u.io(1'b1, 16'h62E1, 8'h11, d);
    wb(1'b0, REG_EVT, 32'h0, q);
    chk("evt", q, 32'h2);
    chk("int_masked", {31'h0, int_o}, 32'h0);
    wb(1'b1, REG_MASK, 32'h2, q);
    repeat (2) @(posedge clk_i);
    chk("int_set", {31'h0, int_o}, 32'h1);
    wb(1'b1, REG_EVT, 32'h2, q);
    repeat (2) @(posedge clk_i);
    chk("int_clr", {31'h0, int_o}, 32'h0);
  endtask

  task automatic t_route;
    logic [5:0] e;
    logic [2:0] f;
    core_irq_i <= 1'b1;
    core_drq_i <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      cfg(1'b0, 1'b0, 7'h57, 2'h0, 3'h7, 3'(j), 2'h1);
      e = (j < 2) ? 6'h00 : 6'(1 << (j - 2));
      chk("irq_oe", {26'h0, isa_irq_oe_n_o}, {26'h0, ~e});
      chk("irq_lvl", {26'h0, isa_irq_o & e}, {26'h0, e});
    end
    cfg(1'b1, 1'b0, 7'h57, 2'h0, 3'h4, 3'h7, 2'h1);
    chk("sh_oe", {26'h0, isa_irq_oe_n_o}, 32'h3B);
    chk("sh_lvl", {31'h0, isa_irq_o[2]}, 32'h1);
    core_irq_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("sh_idle", {26'h0, isa_irq_oe_n_o}, 32'h3F);
    cfg(1'b0, 1'b0, 7'h57, 2'h0, 3'h4, 3'h3, 2'h1);
    chk("ex_oe", {26'h0, isa_irq_oe_n_o}, 32'h3D);
    chk("ex_lvl", {31'h0, isa_irq_o[1]}, 32'h0);
    for (int d = 0; d < 4; d++) begin
      cfg(1'b0, 1'b0, 7'h57, 2'h0, 3'h7, 3'h7, 2'(d));
      f = (d == 0) ? 3'h0 : 3'(1 << (d - 1));
      chk("drq_oe", {29'h0, isa_drq_oe_n_o}, {29'h0, ~f});
      chk("drq", {29'h0, isa_drq_o & f}, {29'h0, f});
      isa_dack_n_i <= ~f;
      repeat (5) @(posedge clk_i);
      chk("dack", {31'h0, core_dack_o}, 32'(d != 0));
      isa_dack_n_i <= ~{f[1:0], f[2]};
      repeat (5) @(posedge clk_i);
      chk("dack_other", {31'h0, core_dack_o}, 32'h0);
      isa_dack_n_i <= 3'h7;
    end
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    {sw_sparse_mode_i, sw_pers_alt_i, sw_sparse_sel_i} = 4'h0;
    sw_base_i = 7'h57;
    {irq_level_switch_i, irq_jumper_i} = 6'h3F;
    dma_jumper_i = 2'h1;
    isa_dack_n_i = 3'h7;
    {core_irq_i, core_drq_i} = 2'h0;
    core_rdata_i = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_reset;
    t_cont;
    t_sparse;
    t_irq;
    t_route;
    wrap_up;
  end
endmodule
`default_nettype wire
